// [dv/trace_far_side.sv]
/*
  Far-side model: trace sources on every slave port and trace sink on the master port.
  Assumes the bench changes pat and sync_fire just after rising clk edges.
*/
`timescale 1ns/1ps
module trace_far_side
#(
   parameter int NPORTS = 8,
   parameter int DW     = 128
)
(
   input  wire logic                 clk,
   input  wire logic [7:0]           pat,
   input  wire logic                 sync_fire,
   output logic      [NPORTS*DW-1:0] atdata_s,
   output logic      [NPORTS*7-1:0]  atid_s,
   output logic      [NPORTS*2-1:0]  atbytes_s,
   output logic      [NPORTS-1:0]    atvalid_s,
   output logic      [NPORTS-1:0]    afready_s,
   output logic                      atready_m,
   output logic                      afvalid_m,
   output logic                      syncreq_m
);
   logic [7:0] s;
   // Own seed per port, so a wrong port select reads differently
   always_comb
   begin
      s = 8'h00;
      for (int p = 0; p < NPORTS; p++)
      begin
         s = pat ^ 8'(p * 37);
         for (int k = 0; k < DW / 8; k++)
            atdata_s[p*DW+8*k +: 8] = s + 8'(k);
         atid_s[p*7 +: 7] = s[6:0];
         atbytes_s[p*2 +: 2] = s[1:0];
         atvalid_s[p] = s[2];
         afready_s[p] = s[3];
      end
      atready_m = pat[0];
      afvalid_m = pat[1];
   end
   // Sink sync request, a one-cycle pulse
   always_ff @(posedge clk)
      syncreq_m <= sync_fire;
endmodule // trace_far_side

// [dv/trace_funnel_integration_test_regs_tb.sv]
/*
  Self-checking bench for the trace funnel integration-test registers.
  Assumes the far-side model drives all trace ports and APB answers with no wait.
*/
`timescale 1ns/1ps
`include "trace_funnel_it_map.svh"
module trace_funnel_integration_test_regs_tb;
   import tf_pkg::*;
   localparam int NP = 8;
   localparam int DW = 128;
   localparam int PL [3] = '{0, 5, 7};
   localparam apb_addr_t RA [9] = '{`TF_OFS_FUNNEL_CTRL, `TF_OFS_DATA_TEST, `TF_OFS_SYNC_TEST,
      `TF_OFS_FLUSH_TEST, `TF_OFS_ID_TEST, `TF_OFS_CTRL0_TEST, `TF_OFS_IT_MODE,
      `TF_OFS_CLAIM_SET, `TF_OFS_CLAIM_CLR};
   localparam apb_word_t RE [9] = '{32'h0000_0300, '0, '0, '0, '0, '0, '0, 32'hF, '0};
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  ce = 1'b1;
   logic                  psel = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite = 1'b0;
   apb_addr_t             paddr = '0;
   apb_word_t             pwdata = '0;
   apb_word_t             prdata;
   logic                  pready, pslverr, sync_fire = 1'b0;
   logic [7:0]            pat = 8'h00;
   logic [NP*DW-1:0]      atdata_s;
   logic [NP*7-1:0]       atid_s;
   logic [NP*2-1:0]       atbytes_s;
   logic [NP-1:0]         atvalid_s, afready_s, atready_s, afvalid_s, syncreq_s;
   logic [DW-1:0]         atdata_m;
   logic [6:0]            atid_m;
   logic [1:0]            atbytes_m;
   logic                  atvalid_m, afready_m, atready_m, afvalid_m, syncreq_m, it_mode;
   logic [DW-1:0]         fn_atdata_m = {8{16'hC3A5}};
   logic [6:0]            fn_atid_m = 7'h11;
   logic [1:0]            fn_atbytes_m = 2'h1;
   logic                  fn_atvalid_m = 1'b1;
   logic                  fn_afready_m = 1'b0;
   logic [NP-1:0]         fn_atready_s = 8'h69;
   logic [NP-1:0]         fn_afvalid_s = 8'h96;
   logic [NP-1:0]         fn_syncreq_s = 8'h00;
   logic [`TF_FCTL_W-1:0] funnel_ctrl;
   int                    err_total = 0;
   int                    samples_checked = 0;
   int                    sync_pulses = 0;
   logic [NP-1:0]         sync_seen = '0;

   always #4 clk = ~clk;

   trace_funnel_it_regs #(.NPORTS(NP), .DW(DW)) DUT (
      .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .atdata_s(atdata_s), .atid_s(atid_s), .atbytes_s(atbytes_s), .atvalid_s(atvalid_s),
      .afready_s(afready_s), .atready_s(atready_s), .afvalid_s(afvalid_s),
      .syncreq_s(syncreq_s), .atdata_m(atdata_m), .atid_m(atid_m), .atbytes_m(atbytes_m),
      .atvalid_m(atvalid_m), .afready_m(afready_m), .atready_m(atready_m),
      .afvalid_m(afvalid_m), .syncreq_m(syncreq_m), .fn_atdata_m(fn_atdata_m),
      .fn_atid_m(fn_atid_m), .fn_atbytes_m(fn_atbytes_m), .fn_atvalid_m(fn_atvalid_m),
      .fn_afready_m(fn_afready_m), .fn_atready_s(fn_atready_s),
      .fn_afvalid_s(fn_afvalid_s), .fn_syncreq_s(fn_syncreq_s),
      .funnel_ctrl(funnel_ctrl), .it_mode(it_mode));

   trace_far_side #(.NPORTS(NP), .DW(DW)) far (
      .clk(clk), .pat(pat), .sync_fire(sync_fire), .atdata_s(atdata_s), .atid_s(atid_s),
      .atbytes_s(atbytes_s), .atvalid_s(atvalid_s), .afready_s(afready_s),
      .atready_m(atready_m), .afvalid_m(afvalid_m), .syncreq_m(syncreq_m));

   // Count cycles with a sync pulse toward the sources
   always @(posedge clk)
   begin
      if (syncreq_s !== '0)
      begin
         sync_pulses++;
         sync_seen = syncreq_s;
      end
   end

   task automatic chk(input logic [31:0] seen, exp, input string m);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high, for at most 8 access cycles
   task automatic apb(input logic wr, input apb_addr_t a, input apb_word_t d,
                      output apb_word_t q);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 8);
      chk({31'h0, pready}, 32'h1, "pready");
      chk({31'h0, pslverr}, 32'h0, "pslverr");
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input apb_addr_t a, input apb_word_t d);
      apb_word_t q;
      apb(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input apb_addr_t a, input apb_word_t e, input string m);
      apb_word_t q;
      apb(1'b0, a, '0, q);
      chk(q, e, m);
   endtask

   task automatic wait3();
      repeat (3) @(posedge clk);
   endtask

   // Data test bit 0 is trace bit 0, bit i is trace bit 8i-1
   function automatic apb_word_t exp_data(input logic [7:0] s);
      apb_word_t  e;
      logic [7:0] b;
      e = '0;
      e[0] = s[0];
      for (int i = 1; i < 17; i++)
      begin
         b = s + 8'(i - 1);
         e[i] = b[7];
      end
      return e;
   endfunction

   task automatic t_reset();
      for (int i = 0; i < 9; i++)
         rd_chk(RA[i], RE[i], "reset value");
      chk(32'(funnel_ctrl), 32'h0000_0300, "port enables");
      $display("reset test done");
   endtask

   // Test writes made outside integration mode must not reach the pins
   task automatic t_normal();
      wr(`TF_OFS_ID_TEST, 32'h0000_005A);
      wr(`TF_OFS_FLUSH_TEST, 32'h0000_0003);
      wr(`TF_OFS_CTRL0_TEST, 32'h0000_0303);
      fn_atid_m <= 7'h22;
      wait3();
      chk(32'(atid_m), 32'h22, "id path");
      chk(32'(afvalid_s), 32'h96, "afvalid path");
      chk(32'(atready_s), 32'h69, "atready path");
      chk(32'(atbytes_m), 32'h1, "bytes path");
      chk(32'(atvalid_m), 32'h1, "valid path");
      chk(32'(afready_m), 32'h0, "afready path");
      chk(atdata_m[31:0], 32'hC3A5_C3A5, "data path");
      $display("normal mode test done");
   endtask

   task automatic t_slave_view();
      int         p;
      logic [7:0] s;
      wr(`TF_OFS_IT_MODE, 32'h1);
      rd_chk(`TF_OFS_IT_MODE, 32'h1, "mode bit");
      chk(32'(it_mode), 32'h1, "mode pin");
      for (int j = 0; j < 3; j++)
      begin
         p = PL[j];
         wr(`TF_OFS_FUNNEL_CTRL, 32'h0000_0300 | (32'h1 << p));
         pat <= 8'h3C + 8'(p);
         wait3();
         s = pat ^ 8'(p * 37);
         rd_chk(`TF_OFS_FUNNEL_CTRL, 32'h0000_0300 | (32'h1 << p), "enables");
         rd_chk(`TF_OFS_DATA_TEST, exp_data(s), "data view");
         rd_chk(`TF_OFS_ID_TEST, {25'h0, s[6:0]}, "id view");
         rd_chk(`TF_OFS_CTRL0_TEST, {22'h0, s[1:0], 6'h0, s[3:2]}, "ctrl0");
         rd_chk(`TF_OFS_FLUSH_TEST, {30'h0, pat[1:0]}, "master in");
      end
      $display("slave view test done");
   endtask

   // Port 7 alone is enabled from here on
   task automatic t_master_drive();
      apb_word_t e;
      wr(`TF_OFS_DATA_TEST, 32'h0001_A5C3);
      wr(`TF_OFS_FLUSH_TEST, 32'h2);
      wr(`TF_OFS_ID_TEST, 32'h5A);
      wr(`TF_OFS_CTRL0_TEST, 32'h0000_0202);
      wait3();
      e = '0;
      e[0] = atdata_m[0];
      for (int i = 1; i < 17; i++)
         e[i] = atdata_m[8*i-1];
      chk(e, 32'h0001_A5C3, "data out");
      chk(32'(afvalid_s), 32'h80, "afvalid out");
      chk(32'(atready_s), 32'h0, "atready out");
      chk(32'(atid_m), 32'h5A, "id out");
      chk({atbytes_m, afready_m, atvalid_m}, 32'hA, "ctrl0 out");
      wr(`TF_OFS_FLUSH_TEST, 32'h1);
      wr(`TF_OFS_CTRL0_TEST, 32'h0000_0101);
      wait3();
      chk({afvalid_s, atready_s}, 32'h0080, "flush out");
      chk({atbytes_m, afready_m, atvalid_m}, 32'h5, "ctrl0 out");
      $display("master drive test done");
   endtask

   task automatic t_sync();
      @(posedge clk);
      sync_fire <= 1'b1;
      @(posedge clk);
      sync_fire <= 1'b0;
      wait3();
      rd_chk(`TF_OFS_SYNC_TEST, 32'h1, "sync latched");
      rd_chk(`TF_OFS_SYNC_TEST, 32'h0, "sync cleared");
      // Pulse timed onto the read's setup edge, seen through the live path
      @(posedge clk);
      sync_fire <= 1'b1;
      fork
         begin
            @(posedge clk);
            sync_fire <= 1'b0;
         end
         rd_chk(`TF_OFS_SYNC_TEST, 32'h1, "sync at setup");
      join
      rd_chk(`TF_OFS_SYNC_TEST, 32'h0, "sync read clears");
      sync_pulses = 0;
      wr(`TF_OFS_SYNC_TEST, 32'h1);
      wait3();
      chk(32'(sync_pulses), 32'h1, "one pulse");
      chk(32'(sync_seen), 32'h80, "pulse port");
      wr(`TF_OFS_SYNC_TEST, 32'h0);
      wait3();
      chk(32'(sync_pulses), 32'h1, "no pulse");
      $display("sync test done");
   endtask

   task automatic t_claim();
      wr(`TF_OFS_CLAIM_SET, 32'h5);
      rd_chk(`TF_OFS_CLAIM_CLR, 32'h5, "claim set");
      rd_chk(`TF_OFS_CLAIM_SET, 32'hF, "claim impl");
      wr(`TF_OFS_CLAIM_SET, 32'hA);
      wr(`TF_OFS_CLAIM_CLR, 32'h3);
      rd_chk(`TF_OFS_CLAIM_CLR, 32'hC, "claim clear");
      wr(12'h800, 32'hFFFF_FFFF);
      rd_chk(12'h800, 32'h0, "unmapped");
      $display("claim test done");
   endtask

   task automatic t_exit();
      wr(`TF_OFS_IT_MODE, 32'h0);
      wait3();
      chk(32'(it_mode), 32'h0, "mode pin");
      chk(32'(atid_m), 32'h22, "id path");
      chk(32'(afvalid_s), 32'h96, "afvalid path");
      $display("exit test done");
   endtask

   // Clock enable low must hold every register, outputs included
   task automatic t_freeze();
      ce <= 1'b0;
      fn_atid_m <= 7'h33;
      wait3();
      chk(32'(atid_m), 32'h22, "frozen id");
      ce <= 1'b1;
      wait3();
      chk(32'(atid_m), 32'h33, "released id");
      $display("freeze test done");
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Run needs well under 2000 cycles; the margin only cuts a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("watchdog expired");
      report_and_stop();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_normal();
      t_slave_view();
      t_master_drive();
      t_sync();
      t_claim();
      t_exit();
      t_freeze();
      report_and_stop();
   end
endmodule // trace_funnel_integration_test_regs_tb

// [rtl/slave_port_view.sv]
/*
  Registered view of the upstream ports that the port enables select.
  Assumes the inputs are synchronous to clk; several enabled ports are ORed.
*/
`timescale 1ns/1ps
module slave_port_view
#(
   parameter int NPORTS = 8,
   parameter int DW     = 128
)
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                ce,
   input  wire logic [NPORTS-1:0]   port_en,
   input  wire logic [NPORTS*DW-1:0] atdata_s,
   input  wire logic [NPORTS*7-1:0] atid_s,
   input  wire logic [NPORTS*2-1:0] atbytes_s,
   input  wire logic [NPORTS-1:0]   atvalid_s,
   input  wire logic [NPORTS-1:0]   afready_s,
   output logic      [DW-1:0]       view_data,
   output logic      [6:0]          view_id,
   output logic      [1:0]          view_bytes,
   output logic                     view_valid,
   output logic                     view_afready
);
   import tf_pkg::*;

   typedef struct packed {
      logic [DW-1:0] data;
      logic [6:0]    id;
      logic [1:0]    bytes;
      logic          valid;
      logic          afready;
   } view_s;

   view_s view_reg;
   view_s view_next;

   // OR of enabled ports; with one port enabled this is that port alone
   always_comb
   begin
      view_next = '0;
      for (int p = 0; p < NPORTS; p++)
      begin
         if (port_en[p])
         begin
            view_next.data    = view_next.data | atdata_s[p*DW +: DW];
            view_next.id      = view_next.id | atid_s[p*7 +: 7];
            view_next.bytes   = view_next.bytes | atbytes_s[p*2 +: 2];
            view_next.valid   = view_next.valid | atvalid_s[p];
            view_next.afready = view_next.afready | afready_s[p];
         end
      end
   end

   // Sampled once per cycle so reads see a stable value
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         view_reg <= '0;
      else if (ce)
         view_reg <= view_next;
   end

   assign view_data    = view_reg.data;
   assign view_id      = view_reg.id;
   assign view_bytes   = view_reg.bytes;
   assign view_valid   = view_reg.valid;
   assign view_afready = view_reg.afready;
endmodule // slave_port_view

// [rtl/tf_pkg.sv]
/*
  Shared types for the trace funnel integration-test block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tf_pkg;
   typedef logic [31:0] apb_word_t;
   typedef logic [11:0] apb_addr_t;
endpackage

// [rtl/trace_funnel_it_map.svh]
/*
  Register offsets, field positions, reset values and timing for the trace funnel
  integration-test register block.
  Assumes it is included by bare name from files that decode a 12-bit byte address.
*/
`ifndef TRACE_FUNNEL_IT_MAP_SVH
`define TRACE_FUNNEL_IT_MAP_SVH

// Byte offsets inside the 4 KB register window
`define TF_OFS_FUNNEL_CTRL   12'h0000
`define TF_OFS_DATA_TEST     12'h0EEC
`define TF_OFS_SYNC_TEST     12'h0EF0
`define TF_OFS_FLUSH_TEST    12'h0EF4
`define TF_OFS_ID_TEST       12'h0EF8
`define TF_OFS_CTRL0_TEST    12'h0EFC
`define TF_OFS_IT_MODE       12'h0F00
`define TF_OFS_CLAIM_SET     12'h0FA0
`define TF_OFS_CLAIM_CLR     12'h0FA4

// Funnel control fields
`define TF_FCTL_EN_LSB       0
`define TF_FCTL_W            13
`define TF_FCTL_RST          13'h0300

// Test register fields
`define TF_DATA_TEST_W       17
`define TF_SYNC_BIT          0
`define TF_FLUSH_AFV_BIT     1
`define TF_FLUSH_ATR_BIT     0
`define TF_ID_W              7
`define TF_BYTES_LSB         8
`define TF_BYTES_W           2
`define TF_CTRL0_AFR_BIT     1
`define TF_CTRL0_ATV_BIT     0
`define TF_IT_MODE_BIT       0

// Claim tag
`define TF_CLAIM_W           4
`define TF_CLAIM_IMPL        4'hF
`define TF_CLAIM_RST         4'h0

// APB answer timing: one wait-free access phase
`define TF_APB_WAIT_CYCLES   0

`endif

// [rtl/trace_funnel_it_regs.sv]
/*
  Integration-test registers, integration mode bit, funnel port enables and claim
  tag of a trace funnel, reached over APB.
  Assumes a synchronous APB master on clk and a functional funnel datapath that
  supplies the fn_* outputs used outside integration mode.
*/
`timescale 1ns/1ps
`include "trace_funnel_it_map.svh"

// Functional notes
// - Data test bits mirror sampled/driven trace data bits
// - Slave reads show currently enabled upstream ports
// - Sync request pulse latched, cleared by read
// - Writing one emits one upstream sync pulse
// - Flush-valid bit reads master, drives slave
// - Ready bit reads master, drives slave
// - Trace ID field reads slave, drives master
// - Byte-count field reads slave, drives master
// - Flush-ready bit reads slave, drives master
// - Valid bit reads slave, drives master
// - Integration mode bit switches outputs to registers
// - Claim set writes set bits, reads implemented
// - Claim set read returns four ones
// - Claim clear clears, reads value, resets zero
// - Funnel control low bits enable each port
module trace_funnel_it_regs
#(
   parameter int NPORTS = 8,
   parameter int DW     = 128
)
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                ce,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire tf_pkg::apb_addr_t   paddr,
   input  wire tf_pkg::apb_word_t   pwdata,
   output tf_pkg::apb_word_t        prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [NPORTS*DW-1:0] atdata_s,
   input  wire logic [NPORTS*7-1:0] atid_s,
   input  wire logic [NPORTS*2-1:0] atbytes_s,
   input  wire logic [NPORTS-1:0]   atvalid_s,
   input  wire logic [NPORTS-1:0]   afready_s,
   output logic      [NPORTS-1:0]   atready_s,
   output logic      [NPORTS-1:0]   afvalid_s,
   output logic      [NPORTS-1:0]   syncreq_s,
   output logic      [DW-1:0]       atdata_m,
   output logic      [6:0]          atid_m,
   output logic      [1:0]          atbytes_m,
   output logic                     atvalid_m,
   output logic                     afready_m,
   input  wire logic                atready_m,
   input  wire logic                afvalid_m,
   input  wire logic                syncreq_m,
   input  wire logic [DW-1:0]       fn_atdata_m,
   input  wire logic [6:0]          fn_atid_m,
   input  wire logic [1:0]          fn_atbytes_m,
   input  wire logic                fn_atvalid_m,
   input  wire logic                fn_afready_m,
   input  wire logic [NPORTS-1:0]   fn_atready_s,
   input  wire logic [NPORTS-1:0]   fn_afvalid_s,
   input  wire logic [NPORTS-1:0]   fn_syncreq_s,
   output logic [`TF_FCTL_W-1:0]    funnel_ctrl,
   output logic                     it_mode
);
   import tf_pkg::*;

   typedef struct packed {
      logic                         pready;
      apb_word_t                    prdata;
      logic [`TF_FCTL_W-1:0]        fctl;
      logic                         itm;
      logic [`TF_CLAIM_W-1:0]       claim;
      logic                         sync_latch;
      logic [`TF_DATA_TEST_W-1:0]   t_data;
      logic                         t_afv;
      logic                         t_atr;
      logic [`TF_ID_W-1:0]          t_id;
      logic [`TF_BYTES_W-1:0]       t_bytes;
      logic                         t_afr;
      logic                         t_atv;
      logic [DW-1:0]                atdata_m;
      logic [6:0]                   atid_m;
      logic [1:0]                   atbytes_m;
      logic                         atvalid_m;
      logic                         afready_m;
      logic [NPORTS-1:0]            atready_s;
      logic [NPORTS-1:0]            afvalid_s;
      logic [NPORTS-1:0]            syncreq_s;
   } regs_s;

   regs_s          st_reg;
   regs_s          st_next;
   logic [DW-1:0]  v_data;
   logic [6:0]     v_id;
   logic [1:0]     v_bytes;
   logic           v_valid;
   logic           v_afready;
   logic           setup_ph;
   logic           wr_go;
   logic           rd_go;
   logic [NPORTS-1:0] port_en;

   assign port_en  = st_reg.fctl[`TF_FCTL_EN_LSB +: NPORTS];
   assign setup_ph = psel && !penable;
   assign wr_go    = psel && penable && st_reg.pready && pwrite;
   assign rd_go    = psel && penable && st_reg.pready && !pwrite;

   slave_port_view #(
      .NPORTS (NPORTS),
      .DW     (DW)
   ) u_view (
      .clk          (clk),
      .rst_n        (rst_n),
      .ce           (ce),
      .port_en      (port_en),
      .atdata_s     (atdata_s),
      .atid_s       (atid_s),
      .atbytes_s    (atbytes_s),
      .atvalid_s    (atvalid_s),
      .afready_s    (afready_s),
      .view_data    (v_data),
      .view_id      (v_id),
      .view_bytes   (v_bytes),
      .view_valid   (v_valid),
      .view_afready (v_afready)
   );

   // Bit i of the data test register maps to trace data bit 0, 7, 15, ... 8i-1
   function automatic int data_bit(input int i);
      data_bit = (i == 0) ? 0 : 8 * i - 1;
   endfunction

   // Register file, read mux and output steering
   always_comb
   begin
      st_next        = st_reg;
      st_next.pready = setup_ph;                // Answer in the access phase
      // Set wins over the read clear so no pulse is lost
      st_next.sync_latch = syncreq_m || (st_reg.sync_latch &&
                           !(rd_go && paddr == `TF_OFS_SYNC_TEST));
      if (setup_ph && !pwrite)
      begin
         st_next.prdata = '0;
         case (paddr)
            `TF_OFS_FUNNEL_CTRL: st_next.prdata[`TF_FCTL_W-1:0] = st_reg.fctl;
            `TF_OFS_DATA_TEST:
               for (int i = 0; i < `TF_DATA_TEST_W; i++)
                  if (data_bit(i) < DW)
                     st_next.prdata[i] = v_data[data_bit(i)];
            // Include the live input so a pulse in the setup cycle is reported
            `TF_OFS_SYNC_TEST:
               st_next.prdata[`TF_SYNC_BIT] = st_reg.sync_latch || syncreq_m;
            `TF_OFS_FLUSH_TEST:
            begin
               st_next.prdata[`TF_FLUSH_AFV_BIT] = afvalid_m;
               st_next.prdata[`TF_FLUSH_ATR_BIT] = atready_m;
            end
            `TF_OFS_ID_TEST:  st_next.prdata[`TF_ID_W-1:0] = v_id;
            `TF_OFS_CTRL0_TEST:
            begin
               st_next.prdata[`TF_BYTES_LSB +: `TF_BYTES_W] = v_bytes;
               st_next.prdata[`TF_CTRL0_AFR_BIT] = v_afready;
               st_next.prdata[`TF_CTRL0_ATV_BIT] = v_valid;
            end
            `TF_OFS_IT_MODE:   st_next.prdata[`TF_IT_MODE_BIT] = st_reg.itm;
            `TF_OFS_CLAIM_SET: st_next.prdata[`TF_CLAIM_W-1:0] = `TF_CLAIM_IMPL;
            `TF_OFS_CLAIM_CLR: st_next.prdata[`TF_CLAIM_W-1:0] = st_reg.claim;
            default:           st_next.prdata = '0;  // Unmapped reads as zero
         endcase
      end
      // Writes take effect at the end of the access phase
      if (wr_go)
      begin
         case (paddr)
            `TF_OFS_FUNNEL_CTRL: st_next.fctl = pwdata[`TF_FCTL_W-1:0];
            `TF_OFS_DATA_TEST:   st_next.t_data = pwdata[`TF_DATA_TEST_W-1:0];
            `TF_OFS_FLUSH_TEST:
            begin
               st_next.t_afv = pwdata[`TF_FLUSH_AFV_BIT];
               st_next.t_atr = pwdata[`TF_FLUSH_ATR_BIT];
            end
            `TF_OFS_ID_TEST:     st_next.t_id = pwdata[`TF_ID_W-1:0];
            `TF_OFS_CTRL0_TEST:
            begin
               st_next.t_bytes = pwdata[`TF_BYTES_LSB +: `TF_BYTES_W];
               st_next.t_afr   = pwdata[`TF_CTRL0_AFR_BIT];
               st_next.t_atv   = pwdata[`TF_CTRL0_ATV_BIT];
            end
            `TF_OFS_IT_MODE:   st_next.itm = pwdata[`TF_IT_MODE_BIT];
            `TF_OFS_CLAIM_SET: st_next.claim = st_reg.claim | pwdata[`TF_CLAIM_W-1:0];
            `TF_OFS_CLAIM_CLR: st_next.claim = st_reg.claim & ~pwdata[`TF_CLAIM_W-1:0];
            default:           st_next.claim = st_reg.claim;   // Writes elsewhere ignored
         endcase
      end
      // Outputs follow the test registers only in integration mode
      if (st_reg.itm)
      begin
         st_next.atdata_m = '0;
         for (int i = 0; i < `TF_DATA_TEST_W; i++)
            if (data_bit(i) < DW)
               st_next.atdata_m[data_bit(i)] = st_reg.t_data[i];
         st_next.atid_m    = st_reg.t_id;
         st_next.atbytes_m = st_reg.t_bytes;
         st_next.afready_m = st_reg.t_afr;
         st_next.atvalid_m = st_reg.t_atv;
         st_next.afvalid_s = {NPORTS{st_reg.t_afv}} & port_en;
         st_next.atready_s = {NPORTS{st_reg.t_atr}} & port_en;
         // Single-cycle pulse toward every enabled upstream port
         st_next.syncreq_s = (wr_go && paddr == `TF_OFS_SYNC_TEST &&
                              pwdata[`TF_SYNC_BIT]) ? port_en : '0;
      end
      else
      begin
         st_next.atdata_m  = fn_atdata_m;
         st_next.atid_m    = fn_atid_m;
         st_next.atbytes_m = fn_atbytes_m;
         st_next.afready_m = fn_afready_m;
         st_next.atvalid_m = fn_atvalid_m;
         st_next.afvalid_s = fn_afvalid_s;
         st_next.atready_s = fn_atready_s;
         st_next.syncreq_s = fn_syncreq_s;
      end
   end

   // Synchronous reset; clock enable freezes everything
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_reg       <= '0;
         st_reg.fctl  <= `TF_FCTL_RST;
         st_reg.claim <= `TF_CLAIM_RST;
      end
      else if (ce)
         st_reg <= st_next;
   end

   assign prdata      = st_reg.prdata;
   assign pready      = st_reg.pready;
   assign pslverr     = 1'b0;    // Every access completes cleanly
   assign atdata_m    = st_reg.atdata_m;
   assign atid_m      = st_reg.atid_m;
   assign atbytes_m   = st_reg.atbytes_m;
   assign atvalid_m   = st_reg.atvalid_m;
   assign afready_m   = st_reg.afready_m;
   assign atready_s   = st_reg.atready_s;
   assign afvalid_s   = st_reg.afvalid_s;
   assign syncreq_s   = st_reg.syncreq_s;
   assign funnel_ctrl = st_reg.fctl;
   assign it_mode     = st_reg.itm;

   // Checks on the register behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence wr_at(logic [11:0] a);
      ce && wr_go && paddr == a;
   endsequence

   sequence rd_setup(logic [11:0] a);
      ce && setup_ph && !pwrite && paddr == a;
   endsequence

   sync_pulse_a: assert property (wr_at(`TF_OFS_SYNC_TEST) ##0 (st_reg.itm &&
         pwdata[0]) |=> syncreq_s == port_en ##1 (!ce || syncreq_s == '0))
      else $error("sync pulse not one cycle to enabled ports");
   sync_zero_a: assert property (wr_at(`TF_OFS_SYNC_TEST) ##0 (st_reg.itm &&
         !pwdata[0]) |=> syncreq_s == '0)
      else $error("sync write of zero produced a pulse");
   sync_latch_a: assert property (ce && syncreq_m |=> st_reg.sync_latch)
      else $error("sync request pulse not latched");
   sync_read_a: assert property (rd_setup(`TF_OFS_SYNC_TEST) ##0 syncreq_m
         |=> prdata[0] && pready)
      else $error("sync request lost on read");
   claim_set_a: assert property (rd_setup(`TF_OFS_CLAIM_SET)
         |=> prdata == 32'h0000_000F)
      else $error("claim set read not all implemented ones");
   claim_clr_a: assert property (wr_at(`TF_OFS_CLAIM_CLR) ##0 (pwdata[3:0] != 4'h0)
         |=> (st_reg.claim & $past(pwdata[3:0])) == 4'h0)
      else $error("claim bits not cleared");
   // Reset sampled as well, so the release edge opens no attempt on reset values
   normal_pass_a: assert property (rst_n && ce && !st_reg.itm
         |=> atvalid_m == $past(fn_atvalid_m) && atid_m == $past(fn_atid_m))
      else $error("functional output disturbed outside integration mode");
   id_drive_a: assert property (wr_at(`TF_OFS_ID_TEST) ##0 st_reg.itm ##1
         (ce && st_reg.itm) |=> atid_m == $past(pwdata[6:0], 2))
      else $error("trace id output not driven from register");
   port_en_a: assert property (wr_at(`TF_OFS_FUNNEL_CTRL)
         |=> funnel_ctrl[7:0] == $past(pwdata[7:0]))
      else $error("port enables not written");
   ready_read_a: assert property (rd_setup(`TF_OFS_FLUSH_TEST)
         |=> prdata[0] == $past(atready_m) && prdata[1] == $past(afvalid_m))
      else $error("flush or ready read wrong");
endmodule // trace_funnel_it_regs
